// >>> rtl/lpp_top.sv
module lpp_top (
	input wire logic MCLK,
	input wire logic RST_N,
	input wire logic PRINTER_PORT_SELECT_N,
	input wire logic SERIAL_SELECT_N,
	input wire logic IO_READ_STROBE_N,
	input wire logic IO_WRITE_STROBE_N,
	input wire logic [2:0] ADDR,
	input wire logic [7:0] DB_IN,
	output logic [7:0] DB_OUT,
	output logic DB_OE,
	output logic BUS_BUFFER_DRIVE,
	input wire logic PRINTER_OE_N,
	input wire logic [7:0] PRINTER_DATA_LINES_IN,
	output logic [7:0] PRINTER_DATA_LINES_OUT,
	output logic PRINTER_DATA_LINES_OE,
	output logic PRINTER_LATCH_STROBE_N_OUT,
	output logic PRINTER_LATCH_STROBE_N_OE,
	output logic AUTO_FEED_N_OUT,
	output logic AUTO_FEED_N_OE,
	output logic INIT_N_OUT,
	output logic INIT_N_OE,
	output logic PRINTER_SELECT_OUT_N_OUT,
	output logic PRINTER_SELECT_OUT_N_OE,
	output logic PRINTER_INTERRUPT_OUT,
	output logic PRINTER_INTERRUPT_OE,
	input wire logic ERROR_N_IN,
	input wire logic PRINTER_SELECTED_IN,
	input wire logic BUSY_IN,
	input wire logic PAPER_EMPTY_IN,
	input wire logic ACK_N_IN
);
	import lpp_pkg::*;

	//////////////////////////////////////////////////////////////////////
	// synchronisers: stage one is read only by stage two
	localparam int NSYNC = 9;
	logic [NSYNC-1:0] raw_in;
	logic [NSYNC-1:0] meta_ff;
	logic [NSYNC-1:0] sync_ff;
	assign raw_in = {PRINTER_PORT_SELECT_N, SERIAL_SELECT_N, IO_READ_STROBE_N,
		IO_WRITE_STROBE_N, ERROR_N_IN, PRINTER_SELECTED_IN, BUSY_IN,
		PAPER_EMPTY_IN, ACK_N_IN};
	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi++) begin : g_sync
			// idle-high reset keeps strobes and selects inactive
			always_ff @(posedge MCLK or negedge RST_N) begin
				if (!RST_N) begin
					meta_ff[gi] <= 1'b1;
					sync_ff[gi] <= 1'b1;
				end else begin
					meta_ff[gi] <= raw_in[gi];
					sync_ff[gi] <= meta_ff[gi];
				end
			end
		end
	endgenerate
	logic lp_sel_n;
	logic ser_sel_n;
	logic rd_n;
	logic wr_n;
	logic err_n;
	logic printer_selected_in;
	logic busy;
	logic pe;
	logic ack_n;
	assign {lp_sel_n, ser_sel_n, rd_n, wr_n, err_n, printer_selected_in, busy, pe, ack_n} = sync_ff;

	// data lines, host address and host write data pass two flops as well;
	// address and data ride alongside the strobe synchronisers, so all of
	// them arrive together; a limitation is that the host must hold address
	// and data stable for the whole strobe
	logic [7:0] pd_meta_ff;
	logic [7:0] pd_ff;
	logic [2:0] addr_meta_ff; // host address, first stage
	logic [2:0] addr_ff; // host address as the logic sees it
	logic [7:0] dbi_meta_ff; // host write data, first stage
	logic [7:0] dbi_ff; // host write data as the logic sees it
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			pd_meta_ff <= 8'h00;
			pd_ff <= 8'h00;
			addr_meta_ff <= 3'h0;
			addr_ff <= 3'h0;
			dbi_meta_ff <= 8'h00;
			dbi_ff <= 8'h00;
		end else begin
			pd_meta_ff <= PRINTER_DATA_LINES_IN;
			pd_ff <= pd_meta_ff;
			// second stages are the only readers of the first
			addr_meta_ff <= ADDR;
			addr_ff <= addr_meta_ff;
			dbi_meta_ff <= DB_IN;
			dbi_ff <= dbi_meta_ff;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// module state
	typedef struct packed {
		lpp_acc_e wr_st;   // write strobe tracker
		logic ack_prev;    // acknowledge seen last cycle
		logic irq_pend;    // sticky acknowledge edge
		logic [7:0] data;  // write data register
		logic [4:0] ctl;   // write control register
		logic [7:0] rdat;  // read data holding register
		logic rd_act;      // a read is in progress
		logic oe_n;        // synced output enable
		logic oe_meta;     // first stage of output enable
		logic dbg_wr;      // checker aid: write just accepted by the buffer
	} lpp_top_s;
	lpp_top_s cur_ff;
	lpp_top_s nxt_st;

	lpp_wr_if wq_in ();
	lpp_wr_if wq_out ();

	// two-entry buffer between the host strobe and the register file
	lpp_buf #(.DEPTH(LPP_BUF_DEPTH)) u_buf (
		.MCLK(MCLK),
		.RST_N(RST_N),
		.in_p(wq_in),
		.out_p(wq_out)
	);

	logic wr_fall;
	logic lp_rd;
	logic ack_rise;
	// falling edge of the write strobe with the printer port selected
	assign wr_fall = (cur_ff.wr_st == LPP_IDLE) && !wr_n && !lp_sel_n;
	assign lp_rd = !rd_n && !lp_sel_n;
	assign ack_rise = !cur_ff.ack_prev && ack_n;
	assign wq_in.valid = wr_fall;
	assign wq_in.addr = addr_ff;
	assign wq_in.data = dbi_ff;
	// register file always takes the word; the buffer covers a host burst
	assign wq_out.ready = 1'b1;

	// next state
	always_comb begin
		nxt_st = cur_ff;
		nxt_st.oe_meta = PRINTER_OE_N;
		nxt_st.oe_n = cur_ff.oe_meta;
		nxt_st.ack_prev = ack_n;
		nxt_st.dbg_wr = wr_fall && wq_in.ready;
		// strobe tracker: one word per strobe; a full buffer drops it
		unique case (cur_ff.wr_st)
			LPP_IDLE: begin
				if (wr_fall) begin
					nxt_st.wr_st = LPP_ACCESS;
				end
			end
			LPP_ACCESS: begin
				if (wr_n) begin
					nxt_st.wr_st = LPP_IDLE;
				end
			end
		endcase
		// drain buffer into the addressed register
		if (wq_out.valid) begin
			if (wq_out.addr == LPP_ADDR_DATA) begin
				nxt_st.data = wq_out.data;
			end else if (wq_out.addr == LPP_ADDR_CTRL) begin
				nxt_st.ctl = wq_out.data[4:0];
			end
		end
		// reading status clears the pending edge, but a new edge wins
		if (lp_rd && !cur_ff.rd_act && addr_ff == LPP_ADDR_STATUS) begin
			nxt_st.irq_pend = 1'b0;
		end
		if (ack_rise) begin
			nxt_st.irq_pend = 1'b1;
		end
		// read data captured at the start of each read
		nxt_st.rd_act = lp_rd;
		if (lp_rd && !cur_ff.rd_act) begin
			unique case (addr_ff)
				LPP_ADDR_DATA: nxt_st.rdat = pd_ff;
				LPP_ADDR_STATUS: nxt_st.rdat = {~busy, ack_n, pe, printer_selected_in, err_n,
					cur_ff.irq_pend, 2'b11};
				LPP_ADDR_CTRL: nxt_st.rdat = {3'b111, cur_ff.ctl};
				default: nxt_st.rdat = 8'hFF;
			endcase
		end
	end

	// state register
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			cur_ff <= '{wr_st: LPP_IDLE, ack_prev: 1'b1, irq_pend: 1'b0,
				data: LPP_DATA_RST, ctl: LPP_CTL_RST, rdat: 8'h00, rd_act: 1'b0,
				oe_n: 1'b1, oe_meta: 1'b1, dbg_wr: 1'b0};
		end else begin
			cur_ff <= nxt_st;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// outputs
	// the serial half shares the bus driver, so its reads also steer it
	assign BUS_BUFFER_DRIVE = !rd_n && (!lp_sel_n || !ser_sel_n);
	assign DB_OUT = cur_ff.rdat;
	assign DB_OE = cur_ff.rd_act;
	assign PRINTER_DATA_LINES_OUT = cur_ff.data;
	assign PRINTER_DATA_LINES_OE = !cur_ff.oe_n;
	// the four control pins are open-drain: drive low only, otherwise release
	assign PRINTER_LATCH_STROBE_N_OUT = 1'b0;
	assign PRINTER_LATCH_STROBE_N_OE = cur_ff.ctl[LPP_CTL_STROBE];
	assign AUTO_FEED_N_OUT = 1'b0;
	assign AUTO_FEED_N_OE = cur_ff.ctl[LPP_CTL_AUTOFEED];
	assign INIT_N_OUT = 1'b0;
	// init pulls low while its bit is clear, like the usual port wiring
	assign INIT_N_OE = !cur_ff.ctl[LPP_CTL_INIT];
	assign PRINTER_SELECT_OUT_N_OUT = 1'b0;
	assign PRINTER_SELECT_OUT_N_OE = cur_ff.ctl[LPP_CTL_SELECT];
	assign PRINTER_INTERRUPT_OE = cur_ff.ctl[LPP_CTL_IRQ_EN];
	assign PRINTER_INTERRUPT_OUT = cur_ff.ctl[LPP_CTL_IRQ_EN] && cur_ff.irq_pend;

	//////////////////////////////////////////////////////////////////////
	// checks
	sequence s_ack_edge;
		!ack_n ##1 ack_n;
	endsequence
	sequence s_irq_seen;
		cur_ff.irq_pend;
	endsequence
	property p_irq_edge;
		@(posedge MCLK) disable iff (!RST_N) s_ack_edge |=> s_irq_seen;
	endproperty
	a_irq_edge: assert property (p_irq_edge) else $error("ack edge lost");
	property p_irq_en;
		@(posedge MCLK) disable iff (!RST_N)
			PRINTER_INTERRUPT_OUT |-> PRINTER_INTERRUPT_OE && cur_ff.ctl[LPP_CTL_IRQ_EN];
	endproperty
	a_irq_en: assert property (p_irq_en) else $error("irq without enable");
	property p_irq_idle;
		@(posedge MCLK) disable iff (!RST_N)
			(PRINTER_INTERRUPT_OE && !cur_ff.irq_pend) |-> !PRINTER_INTERRUPT_OUT;
	endproperty
	a_irq_idle: assert property (p_irq_idle) else $error("irq not low");
	property p_cs;
		@(posedge MCLK) disable iff (!RST_N) lp_sel_n |=> !cur_ff.dbg_wr;
	endproperty
	a_cs: assert property (p_cs) else $error("write without select");
	property p_bdo;
		@(posedge MCLK) disable iff (!RST_N)
			BUS_BUFFER_DRIVE == (!rd_n && !(lp_sel_n && ser_sel_n));
	endproperty
	a_bdo: assert property (p_bdo) else $error("bus drive wrong");
	// a high enable pin floats the lines once its two-flop lag has passed
	property p_float;
		@(posedge MCLK) disable iff (!RST_N)
			PRINTER_OE_N |-> ##2 !PRINTER_DATA_LINES_OE;
	endproperty
	a_float: assert property (p_float) else $error("data lines driven");
	property p_data_wr;
		@(posedge MCLK) disable iff (!RST_N)
			(wq_out.valid && wq_out.addr == LPP_ADDR_DATA) |=>
				PRINTER_DATA_LINES_OUT == $past(wq_out.data);
	endproperty
	a_data_wr: assert property (p_data_wr) else $error("data reg stale");
	property p_strobe;
		@(posedge MCLK) disable iff (!RST_N)
			(wq_out.valid && wq_out.addr == LPP_ADDR_CTRL) |=>
				PRINTER_LATCH_STROBE_N_OE == $past(wq_out.data[0]);
	endproperty
	a_strobe: assert property (p_strobe) else $error("strobe mismatch");
	// the interrupt enable follows each control write one cycle after the drain
	property p_irq_oe;
		@(posedge MCLK) disable iff (!RST_N)
			(wq_out.valid && wq_out.addr == LPP_ADDR_CTRL) |=>
				PRINTER_INTERRUPT_OE == $past(wq_out.data[LPP_CTL_IRQ_EN]);
	endproperty
	a_irq_oe: assert property (p_irq_oe) else $error("irq enable stale");
	// a status read with no fresh edge leaves the interrupt output low
	sequence s_status_rd;
		lp_rd && !cur_ff.rd_act && addr_ff == LPP_ADDR_STATUS && !ack_rise;
	endsequence
	property p_irq_clr;
		@(posedge MCLK) disable iff (!RST_N) s_status_rd |=> !PRINTER_INTERRUPT_OUT;
	endproperty
	a_irq_clr: assert property (p_irq_clr) else $error("irq not cleared");
endmodule

// >>> rtl/lpp_pkg.sv
package lpp_pkg;
	// address decode of the printer port registers (three address inputs)
	localparam logic [2:0] LPP_ADDR_DATA = 3'h0;   // write data register / data lines read
	localparam logic [2:0] LPP_ADDR_STATUS = 3'h1; // printer status read
	localparam logic [2:0] LPP_ADDR_CTRL = 3'h2;   // write control register
	// control register field positions
	localparam int LPP_CTL_STROBE = 0;
	localparam int LPP_CTL_AUTOFEED = 1;
	localparam int LPP_CTL_INIT = 2;
	localparam int LPP_CTL_SELECT = 3;
	localparam int LPP_CTL_IRQ_EN = 4;
	// status register field positions
	localparam int LPP_ST_IRQ = 2;
	localparam int LPP_ST_ERROR_N = 3;
	localparam int LPP_ST_SELECTED = 4;
	localparam int LPP_ST_PAPER = 5;
	localparam int LPP_ST_ACK_N = 6;
	localparam int LPP_ST_BUSY_N = 7;
	// values after reset
	localparam logic [7:0] LPP_DATA_RST = 8'h00;
	localparam logic [4:0] LPP_CTL_RST = 5'h00;
	// buffer depth
	localparam int LPP_BUF_DEPTH = 2;
	// strobe edge states
	typedef enum logic [1:0] {
		LPP_IDLE = 2'b00,
		LPP_ACCESS = 2'b01
	} lpp_acc_e;
endpackage

// >>> rtl/lpp_wr_if.sv
// write path between bus front end and printer side
interface lpp_wr_if;
	logic valid;     // a write word is offered
	logic ready;     // the taker accepts it
	logic [2:0] addr;
	logic [7:0] data;
	modport src (output valid, output addr, output data, input ready);
	modport dst (input valid, input addr, input data, output ready);
endinterface

// >>> rtl/lpp_buf.sv
// two-entry buffer on the write path; a stalled taker loses no word
module lpp_buf #(
	parameter int DEPTH = 2
) (
	input wire logic MCLK,
	input wire logic RST_N,
	lpp_wr_if.dst in_p,
	lpp_wr_if.src out_p
);
	import lpp_pkg::*;
	typedef struct packed {
		logic [1:0][10:0] mem;
		logic [1:0] cnt;
		logic rd;
		logic wr;
	} lpp_buf_s;
	lpp_buf_s cur_ff;
	lpp_buf_s nxt_st;
	logic push;
	logic pop;
	//////////////////////////////////////////////////////////////////////
	// full and empty come straight from the occupancy count
	assign in_p.ready = (cur_ff.cnt != 2'(DEPTH));
	assign out_p.valid = (cur_ff.cnt != 2'h0);
	assign out_p.addr = cur_ff.mem[cur_ff.rd][10:8];
	assign out_p.data = cur_ff.mem[cur_ff.rd][7:0];
	assign push = in_p.valid && in_p.ready;
	assign pop = out_p.valid && out_p.ready;
	// next state
	always_comb begin
		nxt_st = cur_ff;
		if (push) begin
			nxt_st.mem[cur_ff.wr] = {in_p.addr, in_p.data};
			nxt_st.wr = ~cur_ff.wr;
		end
		if (pop) begin
			nxt_st.rd = ~cur_ff.rd;
		end
		nxt_st.cnt = cur_ff.cnt + 2'(push) - 2'(pop);
	end
	// state register
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			cur_ff <= '0;
		end else begin
			cur_ff <= nxt_st;
		end
	end
	// occupancy never exceeds depth
	property p_buf_bound;
		@(posedge MCLK) disable iff (!RST_N) cur_ff.cnt <= 2'(DEPTH);
	endproperty
	a_buf_bound: assert property (p_buf_bound) else $error("buffer overfilled");
endmodule

// >>> test/lpp_printer.sv
// behavioural line printer on the far side of the port
module lpp_printer (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic strobe_n,
	input wire logic select_n,
	input wire logic [7:0] data,
	input wire logic fault,
	input wire logic no_paper,
	output logic error_n,
	output logic selected,
	output logic busy,
	output logic paper_empty,
	output logic ack_n,
	output logic [7:0] latched
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [3:0] cnt_ff; // cycles left in the current transfer
	////////////////////////////////////////////////////////////////
	// status levels follow the printer's condition each cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			{error_n, selected, busy, paper_empty, ack_n} <= 5'b1_0001;
			cnt_ff <= 4'h0;
			latched <= 8'h00;
		end else begin
			error_n <= !fault;
			paper_empty <= no_paper;
			selected <= !select_n;
			// a long busy span keeps one strobe from being taken twice
			if (!busy && !strobe_n) begin
				busy <= 1'b1;
				latched <= data;
				cnt_ff <= 4'hf;
			end else if (busy) begin
				cnt_ff <= cnt_ff - 4'h1;
				ack_n <= !(cnt_ff != 4'h0 && cnt_ff <= 4'h4);
				busy <= (cnt_ff != 4'h0);
			end
		end
	end
endmodule

// >>> test/tb.sv
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	import lpp_pkg::*;
	logic MCLK = 0, RST_N = 0, PRINTER_PORT_SELECT_N = 1, SERIAL_SELECT_N = 1;
	logic IO_READ_STROBE_N = 1, IO_WRITE_STROBE_N = 1, PRINTER_OE_N = 0;
	logic [2:0] ADDR = 3'h0;
	logic [7:0] DB_IN = 8'h00, DB_OUT, PRINTER_DATA_LINES_IN, PRINTER_DATA_LINES_OUT, lat;
	logic DB_OE, BUS_BUFFER_DRIVE, PRINTER_DATA_LINES_OE, PRINTER_INTERRUPT_OUT;
	logic PRINTER_LATCH_STROBE_N_OUT, PRINTER_LATCH_STROBE_N_OE, AUTO_FEED_N_OUT;
	logic AUTO_FEED_N_OE, INIT_N_OUT, INIT_N_OE, PRINTER_INTERRUPT_OE;
	logic PRINTER_SELECT_OUT_N_OUT, PRINTER_SELECT_OUT_N_OE;
	logic ERROR_N_IN, PRINTER_SELECTED_IN, BUSY_IN, PAPER_EMPTY_IN, ACK_N_IN;
	logic fault = 0, no_paper = 0;
	logic [7:0] v;
	logic b;
	logic o;
	int error_cnt = 0, checks = 0;
	always #12.5 MCLK = ~MCLK;
	// open-drain lines are pulled up; floated data lines show a foreign pattern
	assign PRINTER_DATA_LINES_IN = PRINTER_DATA_LINES_OE ? PRINTER_DATA_LINES_OUT : 8'h5a;
	lpp_top dut (.MCLK, .RST_N, .PRINTER_PORT_SELECT_N, .SERIAL_SELECT_N, .IO_READ_STROBE_N,
		.IO_WRITE_STROBE_N, .ADDR, .DB_IN, .DB_OUT, .DB_OE, .BUS_BUFFER_DRIVE, .PRINTER_OE_N,
		.PRINTER_DATA_LINES_IN, .PRINTER_DATA_LINES_OUT, .PRINTER_DATA_LINES_OE,
		.PRINTER_LATCH_STROBE_N_OUT, .PRINTER_LATCH_STROBE_N_OE, .AUTO_FEED_N_OUT,
		.AUTO_FEED_N_OE, .INIT_N_OUT, .INIT_N_OE, .PRINTER_SELECT_OUT_N_OUT,
		.PRINTER_SELECT_OUT_N_OE, .PRINTER_INTERRUPT_OUT, .PRINTER_INTERRUPT_OE, .ERROR_N_IN,
		.PRINTER_SELECTED_IN, .BUSY_IN, .PAPER_EMPTY_IN, .ACK_N_IN);
	lpp_printer prn (.clk(MCLK), .rst_n(RST_N),
		.strobe_n(PRINTER_LATCH_STROBE_N_OE ? PRINTER_LATCH_STROBE_N_OUT : 1'b1),
		.select_n(PRINTER_SELECT_OUT_N_OE ? PRINTER_SELECT_OUT_N_OUT : 1'b1),
		.data(PRINTER_DATA_LINES_IN), .fault(fault),
		.no_paper(no_paper), .error_n(ERROR_N_IN), .selected(PRINTER_SELECTED_IN),
		.busy(BUSY_IN), .paper_empty(PAPER_EMPTY_IN), .ack_n(ACK_N_IN), .latched(lat));
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d, error_cnt %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// strobes held 4 cycles low and high, beyond the 2-cycle sync lag
	task automatic wr(input logic [2:0] a, input logic [7:0] d, input logic sel_n);
		@(posedge MCLK);
		ADDR <= a;
		DB_IN <= d;
		PRINTER_PORT_SELECT_N <= sel_n;
		IO_WRITE_STROBE_N <= 1'b0;
		repeat (4) @(posedge MCLK);
		IO_WRITE_STROBE_N <= 1'b1;
		repeat (4) @(posedge MCLK);
		PRINTER_PORT_SELECT_N <= 1'b1;
		repeat (2) @(posedge MCLK);
	endtask
	task automatic rd(input logic [2:0] a, input logic p_n, input logic s_n);
		@(posedge MCLK);
		ADDR <= a;
		PRINTER_PORT_SELECT_N <= p_n;
		SERIAL_SELECT_N <= s_n;
		IO_READ_STROBE_N <= 1'b0;
		repeat (5) @(posedge MCLK);
		#1 v = DB_OUT;
		b = BUS_BUFFER_DRIVE;
		o = DB_OE;
		@(posedge MCLK);
		IO_READ_STROBE_N <= 1'b1;
		repeat (4) @(posedge MCLK);
		{PRINTER_PORT_SELECT_N, SERIAL_SELECT_N} <= 2'b11;
		@(posedge MCLK);
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_reset();
		chk({INIT_N_OE, PRINTER_LATCH_STROBE_N_OE, AUTO_FEED_N_OE, PRINTER_INTERRUPT_OE,
			PRINTER_SELECT_OUT_N_OE, BUS_BUFFER_DRIVE, DB_OE, 1'b0}, 8'h80);
	endtask
	task automatic t_data();
		wr(LPP_ADDR_DATA, 8'ha5, 1'b0);
		chk(PRINTER_DATA_LINES_OUT, 8'ha5);
		chk({7'h0, PRINTER_DATA_LINES_OE}, 8'h01);
		wr(LPP_ADDR_DATA, 8'h3c, 1'b1);
		chk(PRINTER_DATA_LINES_OUT, 8'ha5);
		PRINTER_OE_N <= 1'b1;
		repeat (6) @(posedge MCLK);
		chk({7'h0, PRINTER_DATA_LINES_OE}, 8'h00);
		rd(LPP_ADDR_DATA, 1'b0, 1'b1);
		chk(v, 8'h5a);
		PRINTER_OE_N <= 1'b0;
	endtask
	task automatic t_ctl();
		// one control bit at a time; the initialize line is inverted
		for (int i = 0; i < 4; i++) begin
			wr(LPP_ADDR_CTRL, 8'h01 << i, 1'b0);
			chk({4'h0, PRINTER_SELECT_OUT_N_OE, INIT_N_OE, AUTO_FEED_N_OE,
				PRINTER_LATCH_STROBE_N_OE}, (8'h01 << i) ^ 8'h04);
			chk({4'h0, PRINTER_SELECT_OUT_N_OUT, INIT_N_OUT, AUTO_FEED_N_OUT,
				PRINTER_LATCH_STROBE_N_OUT}, 8'h00);
		end
	endtask
	task automatic t_read();
		rd(3'h5, 1'b0, 1'b1);
		chk({v[7:1], b}, 8'hff);
		chk({7'h0, o}, 8'h01);
		rd(LPP_ADDR_STATUS, 1'b1, 1'b0);
		chk({7'h0, b}, 8'h01);
		chk({7'h0, o}, 8'h00);
		rd(LPP_ADDR_STATUS, 1'b1, 1'b1);
		chk({7'h0, b}, 8'h00);
	endtask
	// print one byte with the interrupt enabled or not
	task automatic t_print(input logic en);
		int n;
		wr(LPP_ADDR_CTRL, {3'h0, en, 4'h8}, 1'b0);
		chk({7'h0, PRINTER_INTERRUPT_OE}, {7'h0, en});
		chk({7'h0, PRINTER_INTERRUPT_OUT}, 8'h00);
		wr(LPP_ADDR_DATA, 8'hc3, 1'b0);
		wr(LPP_ADDR_CTRL, {3'h0, en, 4'h9}, 1'b0);
		wr(LPP_ADDR_CTRL, {3'h0, en, 4'h8}, 1'b0);
		for (n = 0; n < 40 && BUSY_IN !== 1'b0; n++)
			@(posedge MCLK);
		repeat (5) @(posedge MCLK);
		chk(lat, 8'hc3);
		chk({7'h0, PRINTER_INTERRUPT_OUT}, {7'h0, en});
		rd(LPP_ADDR_STATUS, 1'b0, 1'b1);
		chk(v, 8'hdf);
		chk({7'h0, PRINTER_INTERRUPT_OUT}, 8'h00);
	endtask
	task automatic t_fault();
		fault <= 1'b1;
		no_paper <= 1'b1;
		repeat (6) @(posedge MCLK);
		rd(LPP_ADDR_STATUS, 1'b0, 1'b1);
		chk(v, 8'hf3);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (3) @(posedge MCLK);
		t_reset();
		RST_N <= 1'b1;
		t_data();
		t_ctl();
		t_read();
		t_print(1'b0);
		t_print(1'b1);
		t_fault();
		give_verdict();
	end
	// watchdog well beyond the few hundred cycles the tasks need
	initial begin
		#(25 * 20000);
		error_cnt++;
		give_verdict();
	end
endmodule
